//--- rtl/lce_consts.svh
// Offsets, field positions, reset values and timing counts
`ifndef LCE_CONSTS_SVH
`define LCE_CONSTS_SVH
`define LCE_CLK_MHZ          40
`define LCE_STEP_CLKS        4
`define LCE_PERIOD_CLKS      8
`define LCE_CF_MAX_KHZ       23
`define LCE_CF_MIN_CLKS      ((`LCE_CLK_MHZ * 1000 + `LCE_CF_MAX_KHZ - 1) / `LCE_CF_MAX_KHZ)
`define LCE_CF_WIDTH_CLKS    16
`define LCE_ACC_W            49
`define LCE_RES_W            24
`define LCE_GAIN_W           12
`define LCE_GAIN_SHIFT       12
`define LCE_RES_SAT          24'hffffff
`define LCE_PULSE_RATIO_NUMERATOR_RST        12'h03f
`define LCE_PULSE_RATIO_DENOMINATOR_RST        12'h03f
`define LCE_ACTIVE_ENERGY_DIVIDER_RST         8'h00
`define LCE_APPARENT_ENERGY_DIVIDER_RST        8'h00
`define LCE_HALF_CYCLE_COUNT_SETTING_RST      16'hffff
`define LCE_MASK_RST         1'b0
`define LCE_A_ACT_GAIN       4'h0
`define LCE_A_APP_GAIN       4'h1
`define LCE_A_ACT_DIV        4'h2
`define LCE_A_APP_DIV        4'h3
`define LCE_A_PULSE_RATIO_NUMERATOR          4'h4
`define LCE_A_PULSE_RATIO_DENOMINATOR          4'h5
`define LCE_A_HALF_CYCLE_COUNT_SETTING        4'h6
`define LCE_A_MASK           4'h7
`define LCE_A_STATUS         4'h8
`define LCE_A_APP_RES        4'h9
`define LCE_A_APP_RCLR       4'ha
`define LCE_A_LAPP_RES       4'hb
`define LCE_A_LACT_RES       4'hc
`define LCE_A_ACT_RES        4'hd
`define LCE_A_PERIOD         4'he
`endif

//--- rtl/lce_pkg.sv
// Types shared by the energy accumulator files
package lce_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [23:0] wdata;
  } lce_bus_t;
  typedef enum logic [1:0] {LCE_IDLE, LCE_WAIT_ZX, LCE_RUN} lce_win_t;
endpackage

//--- rtl/lce_scale.sv
// Gain trim applied to a power word; the dividers are applied later in lce_top
`timescale 1ns/1ps
`default_nettype none
`include "lce_consts.svh"
module lce_scale
  import lce_pkg::*;
(
  input  wire logic [23:0] pwr_in,
  input  wire logic [11:0] gain,
  output logic      [24:0] pwr_out
);
  logic signed [37:0] prod;
  always_comb begin
    // Power times (4096 + gain), then drop 12 fraction bits
    // Unity term needs 14 bits, else bit 12 reads as a sign
    prod = $signed({14'h0000, pwr_in})
         * ($signed(14'h1000) + $signed({{2{gain[11]}}, gain}));
    pwr_out = prod[36:12];
  end
endmodule
`default_nettype wire

//--- rtl/lce_pulse.sv
// Ratio-scaled calibration pulse generator driven by active energy
`timescale 1ns/1ps
`default_nettype none
`include "lce_consts.svh"
module lce_pulse
  import lce_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        step,
  input  wire logic [24:0] act_pwr,
  input  wire logic [11:0] num,
  input  wire logic [11:0] den,
  output logic             pulse_q
);
  logic [63:0] acc_q;
  logic [63:0] thr;
  logic [15:0] wid_q;
  logic [15:0] gap_q;
  always_comb begin
    // Widen before adding one so a full-scale setting cannot wrap
    thr = (64'(den) + 64'h1) << 26;
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      acc_q <= 64'h0;
      wid_q <= 16'h0;
      gap_q <= 16'h0;
      pulse_q <= 1'b0;
    end else begin
      if (gap_q != 16'h0)
        gap_q <= gap_q - 16'h1;
      if (wid_q != 16'h0)
        wid_q <= wid_q - 16'h1;
      else
        pulse_q <= 1'b0;
      if (step)
        acc_q <= acc_q + 64'(act_pwr) * (64'(num) + 64'h1);
      else if (acc_q >= thr && gap_q == 16'h0) begin
        acc_q <= acc_q - thr;
        pulse_q <= 1'b1;
        // Output drops a clock after the count empties
        wid_q <= 16'(`LCE_CF_WIDTH_CLKS - 1);
        gap_q <= 16'(`LCE_CF_MIN_CLKS);
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/lce_top.sv
// Apparent and active energy accumulation with line-cycle windows
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lce_consts.svh"
module lce_top
  import lce_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [23:0] reg_rdata,
  input  wire logic [23:0] app_pwr,
  input  wire logic [23:0] act_pwr,
  input  wire logic        zero_cross,
  output logic             calibration_pulse_out,
  output logic             irq_n
);
  lce_bus_t    bus;
  logic [1:0]  div4_q;
  logic [2:0]  div8_q;
  logic        step;
  logic        tick8;
  logic [11:0] apparent_gain_trim_q;
  logic [11:0] active_gain_trim_q;
  logic [7:0]  apparent_energy_divider_q;
  logic [7:0]  active_energy_divider_q;
  logic [11:0] pulse_ratio_numerator_q;
  logic [11:0] pulse_ratio_denominator_q;
  logic [15:0] half_cycle_count_setting_q;
  logic        done_mask_q;
  logic        accumulation_done_flag_q;
  logic [24:0] app_scaled;
  logic [24:0] act_scaled;
  logic [48:0] app_acc_q;
  logic [48:0] act_acc_q;
  logic [48:0] lapp_acc_q;
  logic [48:0] lact_acc_q;
  logic [23:0] line_apparent_energy_result_q;
  logic [23:0] line_active_energy_result_q;
  logic [15:0] half_left_q;
  logic [15:0] per_cnt_q;
  logic [15:0] period_q;
  logic        zx_q;
  logic        zx_edge;
  logic        win_end;
  lce_win_t    win_q;

  // Upper result bits after division, saturated to the readable range
  function automatic logic [23:0] lce_result(input logic [48:0] acc,
                                             input logic [7:0]  dv);
    logic [48:0] q;
    q = (dv == 8'h00) ? acc : acc / 49'(dv);
    lce_result = q[48:24]  > 25'h0ffffff ? `LCE_RES_SAT
               : q[47:24];
  endfunction

  always_comb begin
    bus.wr = reg_wr;
    bus.rd = reg_rd;
    bus.addr = reg_addr;
    bus.wdata = reg_wdata;
    step = (div4_q == 2'(`LCE_STEP_CLKS - 1));
    tick8 = (div8_q == 3'(`LCE_PERIOD_CLKS - 1));
    zx_edge = zero_cross & ~zx_q;
    win_end = (win_q == LCE_RUN) && zx_edge && (half_left_q <= 16'h1);
  end

  // One scaler feeds both continuous and line apparent sums
  lce_scale u_app_scale (
    .pwr_in  (app_pwr),
    .gain    (apparent_gain_trim_q),
    .pwr_out (app_scaled)
  );
  lce_scale u_act_scale (
    .pwr_in  (act_pwr),
    .gain    (active_gain_trim_q),
    .pwr_out (act_scaled)
  );
  // Pulse sees gain-trimmed active power, never the active divider
  lce_pulse u_pulse (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .step    (step),
    .act_pwr (act_scaled),
    .num     (pulse_ratio_numerator_q),
    .den     (pulse_ratio_denominator_q),
    .pulse_q (calibration_pulse_out)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div4_q <= 2'h0;
      div8_q <= 3'h0;
      // High so a pin already high at release is no crossing
      zx_q <= 1'b1;
    end else begin
      div4_q <= div4_q + 2'h1;
      div8_q <= div8_q + 3'h1;
      zx_q <= zero_cross;
    end
  end

  // Settings; no reactive trims exist
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      apparent_gain_trim_q <= 12'h000;
      active_gain_trim_q <= 12'h000;
      apparent_energy_divider_q <= `LCE_APPARENT_ENERGY_DIVIDER_RST;
      active_energy_divider_q <= `LCE_ACTIVE_ENERGY_DIVIDER_RST;
      pulse_ratio_numerator_q <= `LCE_PULSE_RATIO_NUMERATOR_RST;
      pulse_ratio_denominator_q <= `LCE_PULSE_RATIO_DENOMINATOR_RST;
      half_cycle_count_setting_q <= `LCE_HALF_CYCLE_COUNT_SETTING_RST;
      done_mask_q <= `LCE_MASK_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `LCE_A_ACT_GAIN: active_gain_trim_q <= bus.wdata[11:0];
        `LCE_A_APP_GAIN: apparent_gain_trim_q <= bus.wdata[11:0];
        `LCE_A_ACT_DIV:  active_energy_divider_q <= bus.wdata[7:0];
        `LCE_A_APP_DIV:  apparent_energy_divider_q <= bus.wdata[7:0];
        `LCE_A_PULSE_RATIO_NUMERATOR:    pulse_ratio_numerator_q <= bus.wdata[11:0];
        `LCE_A_PULSE_RATIO_DENOMINATOR:    pulse_ratio_denominator_q <= bus.wdata[11:0];
        `LCE_A_HALF_CYCLE_COUNT_SETTING:  half_cycle_count_setting_q <= bus.wdata[15:0];
        `LCE_A_MASK:     done_mask_q <= bus.wdata[0];
        default: ;
      endcase
    end
  end

  // Continuous sums wrap at 49 bits; read-clear zeroes apparent sum, or loads the new sample when it falls on a step
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      app_acc_q <= 49'h0;
      act_acc_q <= 49'h0;
    end else begin
      if (bus.rd && bus.addr == `LCE_A_APP_RCLR)
        app_acc_q <= step ? 49'(app_scaled) : 49'h0;
      else if (step)
        app_acc_q <= app_acc_q + 49'(app_scaled);
      if (step)
        act_acc_q <= act_acc_q + 49'(act_scaled);
    end
  end

  // Window sequencer: first zero crossing opens, count closes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      win_q <= LCE_IDLE;
      half_left_q <= 16'h0;
    end else begin
      unique case (win_q)
        LCE_IDLE: win_q <= LCE_WAIT_ZX;
        LCE_WAIT_ZX: begin
          if (zx_edge) begin
            win_q <= LCE_RUN;
            half_left_q <= half_cycle_count_setting_q;
          end
        end
        LCE_RUN: begin
          if (win_end)
            half_left_q <= half_cycle_count_setting_q;
          else if (zx_edge)
            half_left_q <= half_left_q - 16'h1;
        end
      endcase
    end
  end

  // Both line sums restart on the same edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lapp_acc_q <= 49'h0;
      lact_acc_q <= 49'h0;
      line_apparent_energy_result_q <= 24'h0;
      line_active_energy_result_q <= 24'h0;
    end else if (win_end) begin
      line_apparent_energy_result_q <= lce_result(lapp_acc_q,
                                       apparent_energy_divider_q);
      line_active_energy_result_q <= lce_result(lact_acc_q,
                                     active_energy_divider_q);
      lapp_acc_q <= step ? 49'(app_scaled) : 49'h0;
      lact_acc_q <= step ? 49'(act_scaled) : 49'h0;
    end else if (win_q == LCE_RUN && step) begin
      lapp_acc_q <= lapp_acc_q + 49'(app_scaled);
      lact_acc_q <= lact_acc_q + 49'(act_scaled);
    end
  end

  // Period in ticks of eight clocks between rising crossings
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      per_cnt_q <= 16'h0;
      period_q <= 16'h0;
    end else if (zx_edge) begin
      period_q <= per_cnt_q;
      per_cnt_q <= 16'h0;
    end else if (tick8 && per_cnt_q != 16'hffff) begin
      per_cnt_q <= per_cnt_q + 16'h1;
    end
  end

  // Set wins over a status read that clears
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      accumulation_done_flag_q <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      if (win_end)
        accumulation_done_flag_q <= 1'b1;
      else if (bus.rd && bus.addr == `LCE_A_STATUS)
        accumulation_done_flag_q <= 1'b0;
      irq_n <= ~((accumulation_done_flag_q | win_end) & done_mask_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 24'h0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `LCE_A_ACT_GAIN: reg_rdata <= {12'h0, active_gain_trim_q};
        `LCE_A_APP_GAIN: reg_rdata <= {12'h0, apparent_gain_trim_q};
        `LCE_A_ACT_DIV:  reg_rdata <= {16'h0, active_energy_divider_q};
        `LCE_A_APP_DIV:  reg_rdata <= {16'h0, apparent_energy_divider_q};
        `LCE_A_PULSE_RATIO_NUMERATOR:    reg_rdata <= {12'h0, pulse_ratio_numerator_q};
        `LCE_A_PULSE_RATIO_DENOMINATOR:    reg_rdata <= {12'h0, pulse_ratio_denominator_q};
        `LCE_A_HALF_CYCLE_COUNT_SETTING:  reg_rdata <= {8'h0, half_cycle_count_setting_q};
        `LCE_A_MASK:     reg_rdata <= {23'h0, done_mask_q};
        `LCE_A_STATUS:   reg_rdata <= {23'h0, accumulation_done_flag_q};
        `LCE_A_APP_RES, `LCE_A_APP_RCLR:
          reg_rdata <= lce_result(app_acc_q, apparent_energy_divider_q);
        `LCE_A_LAPP_RES: reg_rdata <= line_apparent_energy_result_q;
        `LCE_A_LACT_RES: reg_rdata <= line_active_energy_result_q;
        `LCE_A_ACT_RES:
          reg_rdata <= lce_result(act_acc_q, active_energy_divider_q);
        `LCE_A_PERIOD:   reg_rdata <= {8'h0, period_q};
        default:         reg_rdata <= 24'h0;
      endcase
    end else begin
      reg_rdata <= 24'h0;
    end
  end

  a_step_period: assert property (@(posedge clk_sys) disable iff (!resetn)
    step |=> !step [*3] ##1 step)
    else $error("accumulation step not every four clocks");
  a_num_reset: assert property (@(posedge clk_sys)
    $rose(resetn) |-> pulse_ratio_numerator_q == 12'h03f
                      && pulse_ratio_denominator_q == 12'h03f)
    else $error("ratio settings not 0x3F after reset");
  a_done_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    win_end |=> accumulation_done_flag_q)
    else $error("done flag not set at window end");
  a_irq_mask: assert property (@(posedge clk_sys) disable iff (!resetn)
    win_end && done_mask_q |=> !irq_n)
    else $error("interrupt not driven low");
  a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    !done_mask_q && !$past(done_mask_q) |-> irq_n)
    else $error("masked interrupt asserted");
  a_line_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(win_end) |-> $stable(line_apparent_energy_result_q))
    else $error("line result changed mid window");
  a_rclr_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.rd && bus.addr == `LCE_A_APP_RCLR && !step
      |=> app_acc_q == 49'h0)
    else $error("read clear did not zero sum");
  a_app_add: assert property (@(posedge clk_sys) disable iff (!resetn)
    step && !(bus.rd && bus.addr == `LCE_A_APP_RCLR)
      |=> app_acc_q == $past(app_acc_q) + 49'($past(app_scaled)))
    else $error("apparent sum not added");
  a_active_energy_divider_reset: assert property (@(posedge clk_sys)
    $rose(resetn) |-> active_energy_divider_q == 8'h00)
    else $error("active divider not zero after reset");
endmodule
`default_nettype wire

//--- testbench/lce_host_model.sv
// Host microcontroller model driving the register port
`timescale 1ns/1ps
`default_nettype none
`include "lce_consts.svh"
module lce_host_model (
  input  wire logic        clk_sys,
  output logic      [3:0]  reg_addr,
  output logic      [23:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [23:0] reg_rdata
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 24'h000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // Idle bus shows inverted values so stale data never passes as valid
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  // Pair read so both line results come from one window
  task automatic rd_line(output logic [23:0] act, output logic [23:0] app);
    rd(`LCE_A_LACT_RES, act);
    rd(`LCE_A_LAPP_RES, app);
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the line-cycle energy accumulator
`timescale 1ns/1ps
`default_nettype none
`include "lce_consts.svh"
module tb_top;
  typedef struct packed {
    logic [3:0]  addr;
    logic [23:0] val;
  } lce_row_t;
  logic        clk_sys;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [23:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [23:0] reg_rdata;
  logic [23:0] app_pwr;
  logic [23:0] act_pwr;
  logic        zero_cross;
  logic        calibration_pulse_out;
  logic        irq_n;
  logic        zx_on;
  logic        meas;
  logic        pulse_prev;
  int          failures;
  int          cmp_count;
  int          rises;
  int          highs;
  int          k;
  logic [23:0] v;
  logic [23:0] w;
  lce_row_t    rows [10];

  lce_top lce_top_inst (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .app_pwr(app_pwr), .act_pwr(act_pwr),
    .zero_cross(zero_cross),
    .calibration_pulse_out(calibration_pulse_out), .irq_n(irq_n)
  );
  lce_host_model lce_host_model_inst (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Half line cycle of 800 clocks
  always begin
    @(posedge clk_sys);
    if (zx_on) begin
      zero_cross <= 1'b1;
      repeat (400) @(posedge clk_sys);
      zero_cross <= 1'b0;
      repeat (399) @(posedge clk_sys);
    end
  end
  always @(posedge clk_sys) begin
    pulse_prev <= calibration_pulse_out;
    if (!meas) begin
      rises <= 0;
      highs <= 0;
    end else if (calibration_pulse_out === 1'b1) begin
      highs <= highs + 1;
      if (pulse_prev !== 1'b1) rises <= rises + 1;
    end
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] inr(input logic [23:0] x,
                                      input int lo, input int hi);
    return (x >= lo && x <= hi) ? 24'h1 : 24'h0;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    lce_host_model_inst.wr(a, d);
  endtask
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    lce_host_model_inst.rd(a, d);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 3000 && irq_n !== 1'b0; i++)
      @(posedge clk_sys);
    check({23'h0, irq_n}, 24'h0);
  endtask
  // Clear, confirm empty, then let 800 clocks accumulate
  task automatic clr_run(input int lo, input int hi);
    logic [23:0] r;
    rd(`LCE_A_APP_RCLR, r);
    rd(`LCE_A_APP_RCLR, r);
    check(r, 24'h0);
    repeat (800) @(posedge clk_sys);
    rd(`LCE_A_APP_RCLR, r);
    check(inr(r, lo, hi), 24'h1);
  endtask
  // Count only whole pulses: start and stop while the output is low
  task automatic pulses(input int n, input int lo, input int hi);
    while (calibration_pulse_out !== 1'b0) @(posedge clk_sys);
    #1 meas = 1'b1;
    repeat (n) @(posedge clk_sys);
    while (calibration_pulse_out !== 1'b0) @(posedge clk_sys);
    #1 meas = 1'b0;
    check(inr(24'(rises), lo, hi), 24'h1);
    check(24'(highs), 24'(16 * rises));
  endtask

  initial begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    app_pwr = 24'h400000;
    act_pwr = 24'h400000;
    zero_cross = 1'b0;
    zx_on = 1'b0;
    meas = 1'b0;
    failures = 0;
    cmp_count = 0;
    rows[0] = {`LCE_A_PULSE_RATIO_NUMERATOR, 24'h00003f};
    rows[1] = {`LCE_A_PULSE_RATIO_DENOMINATOR, 24'h00003f};
    rows[2] = {`LCE_A_ACT_DIV, 24'h000000};
    rows[3] = {`LCE_A_APP_DIV, 24'h000000};
    rows[4] = {`LCE_A_HALF_CYCLE_COUNT_SETTING, 24'h00ffff};
    rows[5] = {`LCE_A_MASK, 24'h000000};
    rows[6] = {`LCE_A_STATUS, 24'h000000};
    rows[7] = {`LCE_A_ACT_GAIN, 24'h000000};
    rows[8] = {`LCE_A_APP_GAIN, 24'h000000};
    rows[9] = {4'hf, 24'h000000};
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].addr, v);
      check(v, rows[i].val);
    end
    $display("reset value test done");
    // Low ratio from the start so no pulse backlog builds up
    wr(`LCE_A_PULSE_RATIO_NUMERATOR, 24'h000000);
    wr(`LCE_A_HALF_CYCLE_COUNT_SETTING, 24'h000002);
    rd(`LCE_A_HALF_CYCLE_COUNT_SETTING, v);
    check(v, 24'h000002);
    wr(`LCE_A_MASK, 24'h000001);
    zx_on = 1'b1;
    wait_irq();
    rd(`LCE_A_STATUS, v);
    check(v, 24'h000001);
    rd(`LCE_A_STATUS, v);
    check(v, 24'h000000);
    repeat (2) @(posedge clk_sys);
    #1 check({23'h0, irq_n}, 24'h1);
    wait_irq();
    lce_host_model_inst.rd_line(v, w);
    check(w, v);
    check(inr(w, 99, 101), 24'h1);
    repeat (200) @(posedge clk_sys);
    rd(`LCE_A_LAPP_RES, v);
    check(v, w);
    wr(`LCE_A_MASK, 24'h000000);
    rd(`LCE_A_STATUS, v);
    k = 0;
    repeat (1700) begin
      @(posedge clk_sys);
      if (irq_n !== 1'b1) k++;
    end
    check(24'(k), 24'h0);
    rd(`LCE_A_STATUS, v);
    check(v, 24'h000001);
    rd(`LCE_A_PERIOD, v);
    check(inr(v, 99, 101), 24'h1);
    $display("line window test done");
    clr_run(49, 51);
    wr(`LCE_A_APP_DIV, 24'h000005);
    clr_run(9, 11);
    wr(`LCE_A_APP_DIV, 24'h000000);
    wr(`LCE_A_APP_GAIN, 24'h000800);
    clr_run(24, 26);
    wr(`LCE_A_APP_GAIN, 24'h000000);
    $display("apparent energy test done");
    wr(`LCE_A_PULSE_RATIO_NUMERATOR, 24'h000000);
    wr(`LCE_A_ACT_DIV, 24'h000005);
    pulses(16384, 3, 5);
    wr(`LCE_A_ACT_DIV, 24'h000000);
    wr(`LCE_A_ACT_GAIN, 24'h0007ff);
    pulses(16384, 5, 7);
    wr(`LCE_A_ACT_GAIN, 24'h000000);
    @(posedge clk_sys);
    act_pwr <= 24'h000000;
    // Let a crossing already in flight fire before counting
    repeat (8) @(posedge clk_sys);
    pulses(8192, 0, 0);
    @(posedge clk_sys);
    act_pwr <= 24'h400000;
    wr(`LCE_A_PULSE_RATIO_NUMERATOR, 24'h00003f);
    wr(`LCE_A_PULSE_RATIO_DENOMINATOR, 24'h000000);
    pulses(17400, 9, 11);
    $display("pulse test done");
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 check({22'h0, irq_n, calibration_pulse_out}, 24'h2);
    for (int i = 0; i < 6; i++) begin
      rd(rows[i].addr, v);
      check(v, rows[i].val);
    end
    $display("second reset test done");
    summarize();
  end
endmodule
`default_nettype wire
